// [logic/bbt_core.v]
// Notes on behaviour
// [R1] Linear bit address is origin plus y times pitch plus x, origin at upper left.
// [R2] Pitch is a bit distance between vertical neighbours and one x step adds one.
// [R3] Each source pixel is combined with its destination pixel by the chosen function and stored.
// [R4] Rectangles are given by pixel address, width in pixels and height in lines, at any bit position.
// [R5] Source data is shifted by the misalignment so the first pixels line up.
// [R6] Destination word bits outside the rectangle keep their old values.
// [R7] All memory reads and writes are whole aligned words, partial updates only by masking.
// [R8] Left mask on every leftmost word, right mask on every rightmost word, both recomputed for each line.
// [R9] A word holds 16 pixels and bit 0 is the first displayed pixel.
// [R10] Functions offered are OR, AND, XOR, fast OR and copy.
// [R11] Bit test, test-and-set, test-and-clear and locked test-and-set, the locked one indivisible.
// [R12] Mask bit zero keeps the destination bit, mask bit one lets the result be written.
// [R13] Inner loop once per spanned word, outer loop once per line, addresses recomputed per line.
// [R14] Inner loop either direction, outer loop either direction, for overlapping blocks.
// [R15] Start pulse takes setup, busy holds during transfer, done pulses once after last write.
`timescale 1ns/1ps
`include "bbt_defines.vh"
module bbt_core #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire clk, // 40 MHz clock
	input wire rst_b, // Async reset, active low
	input wire ce, // Clock enable, freezes all state
	input wire [`BBT_RA_W-1:0] reg_addr, // Register index
	input wire [31:0] reg_wdata, // Write data
	input wire reg_wr, // Write strobe
	input wire reg_rd, // Read strobe
	output reg [31:0] reg_rdata, // Read data, cycle after strobe
	output reg [`BBT_ADDR_W-1:0] mem_addr, // Word address
	output reg mem_req, // Memory request
	output reg mem_we, // Write when high
	output reg [`BBT_WORD_W-1:0] mem_wdata, // Write word
	output reg mem_lock, // Bus lock for locked bit op
	input wire mem_ack, // Access done
	input wire [`BBT_WORD_W-1:0] mem_rdata, // Read word, valid with ack
	output wire busy, // Transfer running
	output reg done // One-cycle completion pulse
);
	localparam W = `BBT_WORD_W;
	localparam AW = `BBT_ADDR_W;
	localparam ST_IDLE = 9'h001;
	localparam ST_LINE = 9'h002;
	localparam ST_SRD = 9'h004;
	localparam ST_DRD = 9'h008;
	localparam ST_DWR = 9'h010;
	localparam ST_NEXT = 9'h020;
	localparam ST_BRD = 9'h040;
	localparam ST_BWR = 9'h080;
	localparam ST_FIN = 9'h100;

	// Combine source and destination by function
	function [W-1:0] bbt_op;
		input [`BBT_FN_W-1:0] fn;
		input [W-1:0] s;
		input [W-1:0] d;
		begin
			case (fn)
				`BBT_FN_AND: bbt_op = s & d;
				`BBT_FN_OR: bbt_op = s | d;
				`BBT_FN_FOR: bbt_op = s | d;
				`BBT_FN_XOR: bbt_op = s ^ d;
				default: bbt_op = s;
			endcase
		end
	endfunction

	// Mask of bits at and above a bit index (bit 0 is first pixel)
	function [W-1:0] bbt_from;
		input [`BBT_BITIDX_W-1:0] b;
		begin
			bbt_from = {W{1'b1}} << b;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register file
	reg [31:0] ctrl_q;
	reg [AW+3:0] src_q, dst_q, org_q;
	reg [`BBT_COORD_W-1:0] width_q, height_q, x_q, y_q;
	reg [AW+3:0] spitch_q, dpitch_q;
	reg done_st_q, bit_q;
	reg [8:0] st_q;
	wire go = reg_wr && reg_addr == `BBT_RA_CTRL && reg_wdata[`BBT_CT_GO] && st_q == ST_IDLE;
	wire bitgo = reg_wr && reg_addr == `BBT_RA_CTRL && reg_wdata[`BBT_CT_BITGO] && st_q == ST_IDLE;
	wire [AW+3:0] lin_addr;
	// Bit address from coordinates
	assign lin_addr = org_q + y_q * dpitch_q + {{(AW+4-`BBT_COORD_W){1'b0}}, x_q}; // [R1] [R2]
	assign busy = (st_q != ST_IDLE); // [R15]

	// Register writes; setup accepted only while idle
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= 32'h0;
			src_q <= {(AW+4){1'b0}};
			dst_q <= {(AW+4){1'b0}};
			org_q <= {(AW+4){1'b0}};
			width_q <= {`BBT_COORD_W{1'b0}};
			height_q <= {`BBT_COORD_W{1'b0}};
			spitch_q <= {(AW+4){1'b0}};
			dpitch_q <= {(AW+4){1'b0}};
			x_q <= {`BBT_COORD_W{1'b0}};
			y_q <= {`BBT_COORD_W{1'b0}};
		end else if (ce && reg_wr && st_q == ST_IDLE) begin
			case (reg_addr)
				`BBT_RA_CTRL: ctrl_q <= reg_wdata;
				`BBT_RA_SRC: src_q <= reg_wdata[AW+3:0];
				`BBT_RA_DST: dst_q <= reg_wdata[AW+3:0];
				`BBT_RA_WIDTH: width_q <= reg_wdata[`BBT_COORD_W-1:0];
				`BBT_RA_HEIGHT: height_q <= reg_wdata[`BBT_COORD_W-1:0];
				`BBT_RA_SPITCH: spitch_q <= reg_wdata[AW+3:0];
				`BBT_RA_DPITCH: dpitch_q <= reg_wdata[AW+3:0];
				`BBT_RA_ORG: org_q <= reg_wdata[AW+3:0];
				`BBT_RA_XY: begin
					x_q <= reg_wdata[15:0];
					y_q <= reg_wdata[31:16];
				end
				default: ;
			endcase
		end
	end

	// Read mux, unmapped reads zero
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			reg_rdata <= 32'h0;
		else if (ce) begin
			if (!reg_rd)
				reg_rdata <= 32'h0;
			else begin
				case (reg_addr)
					`BBT_RA_CTRL: reg_rdata <= ctrl_q;
					`BBT_RA_SRC: reg_rdata <= {{(28-AW){1'b0}}, src_q};
					`BBT_RA_DST: reg_rdata <= {{(28-AW){1'b0}}, dst_q};
					`BBT_RA_WIDTH: reg_rdata <= {16'h0, width_q};
					`BBT_RA_HEIGHT: reg_rdata <= {16'h0, height_q};
					`BBT_RA_SPITCH: reg_rdata <= {{(28-AW){1'b0}}, spitch_q};
					`BBT_RA_DPITCH: reg_rdata <= {{(28-AW){1'b0}}, dpitch_q};
					`BBT_RA_ORG: reg_rdata <= {{(28-AW){1'b0}}, org_q};
					`BBT_RA_XY: reg_rdata <= {y_q, x_q};
					`BBT_RA_STATUS: reg_rdata <= {29'h0, bit_q, done_st_q, busy};
					`BBT_RA_LINADDR: reg_rdata <= {{(28-AW){1'b0}}, lin_addr};
					default: reg_rdata <= 32'h0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transfer geometry, fixed for the whole transfer
	wire dir_x = ctrl_q[`BBT_CT_DIRX];
	wire dir_y = ctrl_q[`BBT_CT_DIRY];
	wire inv = ctrl_q[`BBT_CT_INV] && ctrl_q[`BBT_CT_FN_HI:`BBT_CT_FN_LO] != `BBT_FN_FOR;
	wire [`BBT_FN_W-1:0] fn = ctrl_q[`BBT_CT_FN_HI:`BBT_CT_FN_LO];
	wire [`BBT_BOP_W-1:0] bop = ctrl_q[`BBT_CT_BOP_HI:`BBT_CT_BOP_LO];
	wire [AW+3:0] wm1 = {{(AW+4-`BBT_COORD_W){1'b0}}, width_q} - {{(AW+3){1'b0}}, 1'b1};
	reg [AW+3:0] sl_q, dl_q; // Line start bit addresses
	reg [AW+3:0] sw_q; // Source bit address of current word
	reg [AW-1:0] dwa_q; // Current destination word address
	reg [AW-1:0] dfirst_q, dlast_q; // Line word range
	reg [`BBT_COORD_W-1:0] lines_q;
	reg [W-1:0] lmask_q, rmask_q;
	reg [W-1:0] dst_word_q, sw0_q, sw1_q;
	reg [AW-1:0] sra_q;
	reg shalf_q;
	wire [AW+3:0] dend = dl_q + wm1;
	wire [3:0] dbit0 = dl_q[3:0];
	wire [3:0] dbit1 = dend[3:0];
	// Source bit offset that lands on bit 0 of this destination word
	wire [AW+3:0] dw_bit = {dwa_q, 4'h0};
	wire [AW+3:0] soff = sl_q + (dw_bit - dl_q); // [R5]

	// Funnel shift of two source words into alignment
	wire [2*W-1:0] pair = {sw1_q, sw0_q};
	wire [2*W-1:0] shifted = pair >> sw_q[3:0]; // [R5] [R9]
	wire [W-1:0] src_al = inv ? ~shifted[W-1:0] : shifted[W-1:0];
	wire [W-1:0] emask = (dwa_q == dfirst_q ? lmask_q : {W{1'b1}}) &
		(dwa_q == dlast_q ? rmask_q : {W{1'b1}}); // [R8]
	wire [W-1:0] comb = bbt_op(fn, src_al, dst_word_q); // [R3] [R10]
	wire [W-1:0] merged = (comb & emask) | (dst_word_q & ~emask); // [R6] [R12]

	////////////////////////////////////////////////////////////////////////////
	// Result FIFO stages finished words ahead of the write
	wire fifo_in_ready, fifo_out_valid;
	wire [W-1:0] fifo_out;
	reg fifo_push;
	wire fifo_pop = (st_q == ST_DWR) && mem_req && mem_ack;
	bbt_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.clr(go),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(merged),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sequencer: one word at a time, read source pair, read dest, write
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= ST_IDLE;
			sl_q <= {(AW+4){1'b0}};
			dl_q <= {(AW+4){1'b0}};
			sw_q <= {(AW+4){1'b0}};
			dwa_q <= {AW{1'b0}};
			dfirst_q <= {AW{1'b0}};
			dlast_q <= {AW{1'b0}};
			lines_q <= {`BBT_COORD_W{1'b0}};
			lmask_q <= {W{1'b0}};
			rmask_q <= {W{1'b0}};
			dst_word_q <= {W{1'b0}};
			sw0_q <= {W{1'b0}};
			sw1_q <= {W{1'b0}};
			sra_q <= {AW{1'b0}};
			shalf_q <= 1'b0;
			mem_addr <= {AW{1'b0}};
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_wdata <= {W{1'b0}};
			mem_lock <= 1'b0;
			fifo_push <= 1'b0;
			done <= 1'b0;
			done_st_q <= 1'b0;
			bit_q <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			fifo_push <= 1'b0;
			if (reg_rd && reg_addr == `BBT_RA_STATUS && st_q == ST_IDLE)
				done_st_q <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					if (go && reg_wdata[`BBT_CT_GO] && width_q != 16'h0 && height_q != 16'h0) begin
						// Start from the corner chosen by direction
						// Direction from the start write itself, ctrl_q only catches up at this edge
						sl_q <= reg_wdata[`BBT_CT_DIRY] ? src_q + spitch_q * (height_q - 16'h1) : src_q; // [R14]
						dl_q <= reg_wdata[`BBT_CT_DIRY] ? dst_q + dpitch_q * (height_q - 16'h1) : dst_q; // [R14] [R4]
						lines_q <= height_q;
						done_st_q <= 1'b0;
						st_q <= ST_LINE;
					end else if (bitgo) begin
						mem_addr <= lin_addr[AW+3:4]; // [R7]
						mem_we <= 1'b0;
						mem_req <= 1'b1;
						mem_lock <= reg_wdata[`BBT_CT_BOP_HI:`BBT_CT_BOP_LO] == `BBT_BOP_SETLK; // [R11]
						st_q <= ST_BRD;
					end
				end
				ST_LINE: begin
					// Masks recomputed every line from this line's destination start and end bits
					lmask_q <= bbt_from(dbit0); // [R8]
					rmask_q <= ~({{(W-1){1'b1}}, 1'b0} << dbit1); // [R8]
					dfirst_q <= dl_q[AW+3:4];
					dlast_q <= dend[AW+3:4];
					dwa_q <= dir_x ? dend[AW+3:4] : dl_q[AW+3:4]; // [R14] [R13]
					st_q <= ST_NEXT;
				end
				ST_NEXT: begin
					// Fetch two source words covering this destination word
					sw_q <= soff;
					sra_q <= soff[AW+3:4];
					shalf_q <= 1'b0;
					mem_addr <= soff[AW+3:4]; // [R7]
					mem_we <= 1'b0;
					mem_req <= 1'b1;
					st_q <= ST_SRD;
				end
				ST_SRD: begin
					if (mem_ack) begin
						if (!shalf_q) begin
							sw0_q <= mem_rdata;
							shalf_q <= 1'b1;
							mem_addr <= sra_q + {{(AW-1){1'b0}}, 1'b1};
						end else begin
							sw1_q <= mem_rdata;
							mem_addr <= dwa_q;
							st_q <= ST_DRD;
						end
					end
				end
				ST_DRD: begin
					if (mem_ack) begin
						dst_word_q <= mem_rdata;
						mem_req <= 1'b0;
						fifo_push <= fifo_in_ready;
						st_q <= ST_DWR;
					end
				end
				ST_DWR: begin
					if (!fifo_push && fifo_out_valid && !mem_req) begin
						mem_addr <= dwa_q; // [R7]
						mem_wdata <= fifo_out;
						mem_we <= 1'b1;
						mem_req <= 1'b1;
					end else if (mem_req && mem_ack) begin
						mem_req <= 1'b0;
						mem_we <= 1'b0;
						if (dwa_q != (dir_x ? dfirst_q : dlast_q)) begin
							dwa_q <= dir_x ? dwa_q - {{(AW-1){1'b0}}, 1'b1} : dwa_q + {{(AW-1){1'b0}}, 1'b1}; // [R13]
							st_q <= ST_NEXT;
						end else if (lines_q != 16'h1) begin
							lines_q <= lines_q - 16'h1; // [R13]
							sl_q <= dir_y ? sl_q - spitch_q : sl_q + spitch_q; // [R14]
							dl_q <= dir_y ? dl_q - dpitch_q : dl_q + dpitch_q;
							st_q <= ST_LINE;
						end else
							st_q <= ST_FIN;
					end
				end
				ST_BRD: begin
					if (mem_ack) begin
						bit_q <= mem_rdata[lin_addr[3:0]]; // [R11]
						if (bop == `BBT_BOP_TEST) begin
							mem_req <= 1'b0;
							mem_lock <= 1'b0;
							st_q <= ST_FIN;
						end else begin
							mem_wdata <= (bop == `BBT_BOP_CLEAR) ? mem_rdata & ~({{(W-1){1'b0}}, 1'b1} << lin_addr[3:0])
								: mem_rdata | ({{(W-1){1'b0}}, 1'b1} << lin_addr[3:0]);
							mem_we <= 1'b1;
							st_q <= ST_BWR;
						end
					end
				end
				ST_BWR: begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						mem_we <= 1'b0;
						mem_lock <= 1'b0; // Lock held across read and write [R11]
						st_q <= ST_FIN;
					end
				end
				ST_FIN: begin
					done <= 1'b1; // [R15]
					done_st_q <= 1'b1;
					st_q <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule // bbt_core

// [logic/bbt_defines.vh]
`ifndef BBT_DEFINES_VH
`define BBT_DEFINES_VH
// Word and address geometry
`define BBT_WORD_W 16
`define BBT_ADDR_W 24
`define BBT_BITIDX_W 4
`define BBT_COORD_W 16
// Function codes for block transfers
`define BBT_FN_W 3
`define BBT_FN_COPY 3'h0
`define BBT_FN_AND 3'h1
`define BBT_FN_OR 3'h2
`define BBT_FN_XOR 3'h3
`define BBT_FN_FOR 3'h4
// Bit operation codes
`define BBT_BOP_W 2
`define BBT_BOP_TEST 2'h0
`define BBT_BOP_SET 2'h1
`define BBT_BOP_CLEAR 2'h2
`define BBT_BOP_SETLK 2'h3
// Register offsets (word index)
`define BBT_RA_W 4
`define BBT_RA_CTRL 4'h0
`define BBT_RA_SRC 4'h1
`define BBT_RA_DST 4'h2
`define BBT_RA_WIDTH 4'h3
`define BBT_RA_HEIGHT 4'h4
`define BBT_RA_SPITCH 4'h5
`define BBT_RA_DPITCH 4'h6
`define BBT_RA_ORG 4'h7
`define BBT_RA_XY 4'h8
`define BBT_RA_STATUS 4'h9
`define BBT_RA_LINADDR 4'hA
// Control register fields
`define BBT_CT_GO 0
`define BBT_CT_BITGO 1
`define BBT_CT_DIRX 2
`define BBT_CT_DIRY 3
`define BBT_CT_INV 4
`define BBT_CT_FN_LO 5
`define BBT_CT_FN_HI 7
`define BBT_CT_BOP_LO 8
`define BBT_CT_BOP_HI 9
// Status fields
`define BBT_ST_BUSY 0
`define BBT_ST_DONE 1
`define BBT_ST_BIT 2
`endif

// [logic/bbt_fifo.v]
`timescale 1ns/1ps
// Synchronous FIFO with valid/ready on both sides
module bbt_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk, // Clock
	input wire rst_b, // Async reset, active low
	input wire ce, // Clock enable
	input wire clr, // Synchronous flush
	input wire in_valid, // Write request
	output wire in_ready, // Space available
	input wire [WIDTH-1:0] in_data, // Write word
	output wire out_valid, // Data available
	input wire out_ready, // Read accept
	output wire [WIDTH-1:0] out_data // Head word
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	reg [AW:0] cnt_q;
	wire wr_en;
	wire rd_en;
	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign wr_en = in_valid & in_ready;
	assign rd_en = out_valid & out_ready;
	assign out_data = mem[rp_q];
	// Storage array, no reset needed on data
	always @(posedge clk) begin
		if (ce && wr_en && !clr)
			mem[wp_q] <= in_data;
	end
	// Pointers and fill count
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else if (ce) begin
			if (clr) begin
				wp_q <= {AW{1'b0}};
				rp_q <= {AW{1'b0}};
				cnt_q <= {(AW+1){1'b0}};
			end else begin
				if (wr_en)
					wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
				if (rd_en)
					rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
				if (wr_en && !rd_en)
					cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
				else if (rd_en && !wr_en)
					cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule // bbt_fifo

// [verif/bbt_chk_properties.sv]
`timescale 1ns/1ps
`include "bbt_defines.vh"
module bbt_chk (
	input wire clk, // Clock
	input wire rst_b, // Reset, active low
	input wire ce, // Clock enable
	input wire [`BBT_RA_W-1:0] reg_addr, // Register index
	input wire [31:0] reg_wdata, // Write data
	input wire reg_wr, // Write strobe
	input wire reg_rd, // Read strobe
	input wire [31:0] reg_rdata, // Read data
	input wire [`BBT_ADDR_W-1:0] mem_addr, // Word address
	input wire mem_req, // Memory request
	input wire mem_we, // Write
	input wire [`BBT_WORD_W-1:0] mem_wdata, // Write word
	input wire mem_lock, // Bus lock
	input wire mem_ack, // Access done
	input wire [`BBT_WORD_W-1:0] mem_rdata, // Read word
	input wire busy, // Running
	input wire done // Completion pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Requests hold still until answered, so the access stays one whole word
	chk_req_held:
	assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)) else $error("req moved");
	chk_done_single:
	assert property (done |=> !done) else $error("done too long");
	chk_done_busy:
	assert property (done |-> $past(busy)) else $error("done without busy");
	chk_done_lastack:
	assert property (done |-> $past(mem_ack) || $past(mem_ack, 2) || $past(mem_ack, 3)) else $error("done late");
	chk_lock_busy:
	assert property (mem_lock |-> busy) else $error("lock while idle");
	// Lock must survive from the read answer into the write back
	chk_lock_span:
	assert property (mem_lock && mem_req && mem_ack && !mem_we |=> mem_lock) else $error("lock gap");
	chk_req_busy:
	assert property (mem_req |-> busy) else $error("req while idle");
	chk_bitop_start:
	assert property (ce && reg_wr && reg_addr == `BBT_RA_CTRL && reg_wdata[`BBT_CT_BITGO] && !reg_wdata[`BBT_CT_GO]
		&& !busy |=> busy ##[0:6] (mem_req && !mem_we)) else $error("bit op no read");
endmodule // bbt_chk

bind bbt_core bbt_chk u_chk (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_req(mem_req),
	.mem_we(mem_we), .mem_wdata(mem_wdata), .mem_lock(mem_lock), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
	.busy(busy), .done(done));

// [verif/bbt_fb_mem.sv]
`timescale 1ns/1ps
`include "bbt_defines.vh"
module bbt_fb_mem (
	input wire clk, // Clock
	input wire rst_b, // Reset, active low
	input wire [`BBT_ADDR_W-1:0] mem_addr, // Word address
	input wire mem_req, // Request
	input wire mem_we, // Write
	input wire [`BBT_WORD_W-1:0] mem_wdata, // Write word
	input wire [3:0] slow, // Wait cycles before ack
	output logic mem_ack, // Access done
	output logic [`BBT_WORD_W-1:0] mem_rdata // Read word
);
	logic [15:0] mem [0:63];
	logic [3:0] wait_q;
	// Ack after the wait, always a gap after; stale data flips so it never looks valid
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_ack <= 1'b0;
			wait_q <= 4'h0;
			mem_rdata <= 16'hFFFF;
		end else if (mem_req && !mem_ack && wait_q >= slow) begin
			mem_ack <= 1'b1;
			wait_q <= 4'h0;
			if (mem_we)
				mem[mem_addr[5:0]] <= mem_wdata;
			mem_rdata <= mem_we ? ~mem_rdata : mem[mem_addr[5:0]];
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack)
				wait_q <= wait_q + 4'h1;
		end
	end
endmodule // bbt_fb_mem

// [verif/testbench.sv]
`timescale 1ns/1ps
`include "bbt_defines.vh"
module testbench;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [3:0] slow = 4'h0;
	wire [31:0] reg_rdata;
	wire [23:0] mem_addr;
	wire [15:0] mem_wdata;
	wire [15:0] mem_rdata;
	wire mem_req, mem_we, mem_lock, mem_ack, busy, done;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	always #12.5 clk = ~clk;
	bbt_core u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_req(mem_req),
		.mem_we(mem_we), .mem_wdata(mem_wdata), .mem_lock(mem_lock), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .busy(busy), .done(done));
	bbt_fb_mem u_mem (.clk(clk), .rst_b(rst_b), .mem_addr(mem_addr), .mem_req(mem_req), .mem_we(mem_we),
		.mem_wdata(mem_wdata), .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	////////////////////////////////////////////////////////////////////////////////
	// Common helpers
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic wait_done;
		int n;
		n = 0;
		while (done !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(done, 1'b1);
	endtask
	task automatic lin(input logic [31:0] origin_bit_address, input logic [31:0] p, input logic [15:0] x, input logic [15:0] y);
		logic [31:0] v;
		wr(`BBT_RA_ORG, origin_bit_address);
		wr(`BBT_RA_DPITCH, p);
		wr(`BBT_RA_XY, {y, x});
		rd(`BBT_RA_LINADDR, v);
		check(v, origin_bit_address + y * p + x);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs;
		logic [31:0] v;
		rd(`BBT_RA_STATUS, v);
		check(v, 32'h0);
		rd(4'hF, v);
		check(v, 32'h0);
		lin(32'h1000, 32'h300, 16'h11, 16'h3);
		lin(32'h1000, 32'h300, 16'h12, 16'h3);
		lin(32'h40, 32'h40, 16'h5, 16'h2);
		// A write while the clock enable is low must leave the origin alone
		@(posedge clk);
		ce <= 1'b0;
		wr(`BBT_RA_ORG, 32'h55);
		ce <= 1'b1;
		rd(`BBT_RA_ORG, v);
		check(v, 32'h40);
		$display("test regs finished");
	endtask
	// Bit ops chained on one bit, so each result depends on the one before
	task automatic t_bit;
		logic [31:0] v;
		logic [15:0] w;
		w = 16'hA585;
		u_mem.mem[12] = w;
		slow <= 4'h2;
		for (int op = 0; op < 4; op++) begin
			wr(`BBT_RA_CTRL, 32'h2 + 32'h100 * op);
			wait_done();
			rd(`BBT_RA_STATUS, v);
			check(v[`BBT_ST_BIT], w[5]);
			check(v[`BBT_ST_DONE], 1'b1);
			if (op != 0)
				w[5] = (op != 2);
			check(u_mem.mem[12], w);
		end
		rd(`BBT_RA_STATUS, v);
		check(v[`BBT_ST_DONE], 1'b0);
		$display("test bit ops finished");
	endtask
	task automatic blit(input logic [2:0] fn, input logic inv, input logic dx, input logic dy,
		input int s, input int d, input int w, input int h);
		logic [15:0] snap [0:63];
		logic [15:0] expm [0:63];
		logic sb, db;
		int sa, da;
		for (int i = 0; i < 64; i++) begin
			snap[i] = u_mem.mem[i];
			expm[i] = snap[i];
		end
		// Source always from the snapshot, as an overlap-safe order must give
		for (int l = 0; l < h; l++) begin
			for (int i = 0; i < w; i++) begin
				sa = s + l * 64 + i;
				da = d + l * 64 + i;
				sb = snap[sa >> 4][sa & 15] ^ inv;
				db = expm[da >> 4][da & 15];
				case (fn)
					`BBT_FN_AND: db = sb & db;
					`BBT_FN_XOR: db = sb ^ db;
					`BBT_FN_COPY: db = sb;
					default: db = sb | db;
				endcase
				expm[da >> 4][da & 15] = db;
			end
		end
		wr(`BBT_RA_SRC, s);
		wr(`BBT_RA_DST, d);
		wr(`BBT_RA_WIDTH, w);
		wr(`BBT_RA_HEIGHT, h);
		wr(`BBT_RA_SPITCH, 32'h40);
		wr(`BBT_RA_DPITCH, 32'h40);
		wr(`BBT_RA_CTRL, {24'h0, fn, inv, dy, dx, 2'h1});
		#1;
		check(busy, 1'b1);
		wait_done();
		for (int i = 0; i < 64; i++)
			check(u_mem.mem[i], expm[i]);
	endtask
	task automatic t_blit;
		for (int f = 0; f < 5; f++) begin
			slow <= f[0] ? 4'h3 : 4'h0;
			blit(f[2:0], f[0] & ~f[2], 1'b0, 1'b0, 'h23, 'h109, 'h13, 3);
		end
		blit(`BBT_FN_COPY, 1'b0, 1'b1, 1'b1, 'h23, 'h68, 'h20, 3);
		$display("test blit finished");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	// Main sequence
	initial begin
		for (int i = 0; i < 64; i++)
			u_mem.mem[i] = {i[7:0], ~i[7:0]} ^ 16'h5A3C;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_bit();
		t_blit();
		tally_and_finish();
	end
endmodule // testbench
